// ### core/rtc_regs.svh
// Purpose: register offsets, field positions and reset values of the clock register bank
// Assumes: 32-bit register words, one aligned word per register
// Notes:   included by the package; definitions only
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RTC_ADDR_W          8
`define RTC_OFS_TIME        8'h00
`define RTC_OFS_ALARM       8'h04
`define RTC_OFS_CLKCTL      8'h08
`define RTC_OFS_DSCTL       8'h0C
`define RTC_OFS_STATUS      8'h10

// ----------------------------------------------------------------------------
// time word fields
// ----------------------------------------------------------------------------
`define RTC_HOUR_TEN_MSB    29
`define RTC_HOUR_TEN_LSB    28
`define RTC_HOUR_ONE_MSB    27
`define RTC_HOUR_ONE_LSB    24
`define RTC_MIN_TEN_MSB     22
`define RTC_MIN_TEN_LSB     20
`define RTC_MIN_ONE_MSB     19
`define RTC_MIN_ONE_LSB     16
`define RTC_SEC_TEN_MSB     14
`define RTC_SEC_TEN_LSB     12
`define RTC_SEC_ONE_MSB     11
`define RTC_SEC_ONE_LSB     8

// ----------------------------------------------------------------------------
// alarm date word fields
// ----------------------------------------------------------------------------
`define RTC_MON_TEN_BIT     20
`define RTC_MON_ONE_MSB     19
`define RTC_MON_ONE_LSB     16
`define RTC_DAY_TEN_MSB     13
`define RTC_DAY_TEN_LSB     12
`define RTC_DAY_ONE_MSB     11
`define RTC_DAY_ONE_LSB     8
`define RTC_WDAY_MSB        2
`define RTC_WDAY_LSB        0

// ----------------------------------------------------------------------------
// control and status bits, reset values
// ----------------------------------------------------------------------------
`define RTC_UNLOCK_BIT      3
`define RTC_DSDIS_BIT       12
`define RTC_ST_RUN_BIT      0
`define RTC_ST_DEEP_BIT     1
`define RTC_ST_BATT_BIT     2
`define RTC_ST_TBAD_BIT     3
`define RTC_ST_ABAD_BIT     4
`define RTC_SYNC_RST        3'b111
`endif

// ### core/rtc_pkg.sv
// Purpose: types shared by the clock register bank
// Assumes: rtc_regs.svh supplies widths
// Notes:   packed structs carry the register fields and the bus request
`include "rtc_regs.svh"
package rtc_pkg;

  // ----------------------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] hour_tens_digit;
    logic [3:0] hour_units_digit;
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_units_digit;
    logic [2:0] second_tens_digit;
    logic [3:0] second_units_digit;
  } rtc_time_s;

  typedef struct packed {
    logic       alarm_month_tens_digit;
    logic [3:0] alarm_month_units_digit;
    logic [1:0] alarm_day_tens_digit;
    logic [3:0] alarm_day_units_digit;
    logic [2:0] alarm_weekday_digit;
  } rtc_alarm_s;

  // power state, gray along run -> deep sleep -> battery
  typedef enum logic [1:0] {
    RTC_PM_RUN  = 2'b00,
    RTC_PM_DEEP = 2'b01,
    RTC_PM_BATT = 2'b11
  } rtc_pmode_e;

  typedef struct packed {
    logic [`RTC_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } rtc_bus_req_s;

  typedef struct packed {
    logic       clock_write_unlock;
    logic       deep_sleep_clock_disable;
    logic [2:0] sup_sync;
    logic [2:0] slp_sync;
    logic       supply_ok;
    logic       sleep_req;
    rtc_pmode_e pmode;
    logic       clk_off_latched;
    logic       clock_run;
    logic       wake_pulse;
    logic [31:0] rdata;
  } rtc_ctl_s;

  typedef struct packed {
    rtc_time_s  tm;
    rtc_alarm_s al;
    rtc_ctl_s   ctl;
  } rtc_state_s;

endpackage : rtc_pkg

// ### core/rtc_time_alarm_regs.sv
// Purpose: register bank of the calendar clock unit: time, alarm date, control, power state
// Assumes: reset_n is the backup-domain reset; power pins arrive asynchronously
// Notes:   the counting logic sits outside and follows clock_run_enable
//
// Behaviour
// R1: hour tens digit in bits 29-28
// R2: hour units digit in bits 27-24
// R3: minute tens digit in bits 22-20
// R4: minute units digit in bits 19-16
// R5: second tens digit in bits 14-12
// R6: second units digit in bits 11-8
// R7: unused bits read zero, ignore writes
// R8: time writable only while unlock bit set
// R9: alarm month tens digit at bit 20
// R10: alarm month units digit in bits 19-16
// R11: alarm day tens digit in bits 13-12
// R12: alarm day units digit in bits 11-8
// R13: alarm weekday in bits 2-0
// R14: disable bit at deep sleep entry stops clock
// R15: battery mode honours the same disable bit
// R16: battery mode by hardware, wake looks like reset
// R17: digit fields power up undefined
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_time_alarm_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire rtc_pkg::rtc_bus_req_s bus_req,
  output logic [31:0]               bus_rdata,
  input  wire logic                 main_supply_ok_pin,
  input  wire logic                 deep_sleep_req_pin,
  output logic                      clock_run_enable,
  output logic                      deep_sleep_mode,
  output logic                      battery_mode,
  output logic                      wake_por_pulse
);
  import rtc_pkg::*;

  rtc_state_s st_q;
  rtc_state_s st_d;

  // ----------------------------------------------------------------------------
  // field packing
  // ----------------------------------------------------------------------------
  // unused positions stay zero because only named fields are placed
  function automatic logic [31:0] time_word(input rtc_time_s t);
    logic [31:0] w;
    w = 32'h0000_0000;                                            // see R7
    w[`RTC_HOUR_TEN_MSB:`RTC_HOUR_TEN_LSB] = t.hour_tens_digit;   // see R1
    w[`RTC_HOUR_ONE_MSB:`RTC_HOUR_ONE_LSB] = t.hour_units_digit;  // see R2
    w[`RTC_MIN_TEN_MSB:`RTC_MIN_TEN_LSB]   = t.minute_tens_digit; // see R3
    w[`RTC_MIN_ONE_MSB:`RTC_MIN_ONE_LSB]   = t.minute_units_digit; // see R4
    w[`RTC_SEC_TEN_MSB:`RTC_SEC_TEN_LSB]   = t.second_tens_digit; // see R5
    w[`RTC_SEC_ONE_MSB:`RTC_SEC_ONE_LSB]   = t.second_units_digit; // see R6
    return w;
  endfunction : time_word

  function automatic rtc_time_s time_field(input logic [31:0] w);
    rtc_time_s t;
    t.hour_tens_digit    = w[`RTC_HOUR_TEN_MSB:`RTC_HOUR_TEN_LSB];
    t.hour_units_digit   = w[`RTC_HOUR_ONE_MSB:`RTC_HOUR_ONE_LSB];
    t.minute_tens_digit  = w[`RTC_MIN_TEN_MSB:`RTC_MIN_TEN_LSB];
    t.minute_units_digit = w[`RTC_MIN_ONE_MSB:`RTC_MIN_ONE_LSB];
    t.second_tens_digit  = w[`RTC_SEC_TEN_MSB:`RTC_SEC_TEN_LSB];
    t.second_units_digit = w[`RTC_SEC_ONE_MSB:`RTC_SEC_ONE_LSB];
    return t;
  endfunction : time_field

  function automatic logic [31:0] alarm_word(input rtc_alarm_s a);
    logic [31:0] w;
    w = 32'h0000_0000;                                            // see R7
    w[`RTC_MON_TEN_BIT]                  = a.alarm_month_tens_digit;  // see R9
    w[`RTC_MON_ONE_MSB:`RTC_MON_ONE_LSB] = a.alarm_month_units_digit; // see R10
    w[`RTC_DAY_TEN_MSB:`RTC_DAY_TEN_LSB] = a.alarm_day_tens_digit;    // see R11
    w[`RTC_DAY_ONE_MSB:`RTC_DAY_ONE_LSB] = a.alarm_day_units_digit;   // see R12
    w[`RTC_WDAY_MSB:`RTC_WDAY_LSB]   = a.alarm_weekday_digit;     // see R13
    return w;
  endfunction : alarm_word

  function automatic rtc_alarm_s alarm_field(input logic [31:0] w);
    rtc_alarm_s a;
    a.alarm_month_tens_digit  = w[`RTC_MON_TEN_BIT];
    a.alarm_month_units_digit = w[`RTC_MON_ONE_MSB:`RTC_MON_ONE_LSB];
    a.alarm_day_tens_digit    = w[`RTC_DAY_TEN_MSB:`RTC_DAY_TEN_LSB];
    a.alarm_day_units_digit   = w[`RTC_DAY_ONE_MSB:`RTC_DAY_ONE_LSB];
    a.alarm_weekday_digit     = w[`RTC_WDAY_MSB:`RTC_WDAY_LSB];
    return a;
  endfunction : alarm_field

  // ----------------------------------------------------------------------------
  // digit range checks, shown in status so software sees unloaded values
  // ----------------------------------------------------------------------------
  function automatic logic time_bad(input rtc_time_s t);
    return (t.hour_tens_digit > 2'h2) || (t.hour_units_digit > 4'h9) ||
           (t.minute_tens_digit > 3'h5) || (t.minute_units_digit > 4'h9) ||
           (t.second_tens_digit > 3'h5) || (t.second_units_digit > 4'h9);
  endfunction : time_bad

  function automatic logic alarm_bad(input rtc_alarm_s a);
    return (a.alarm_month_units_digit > 4'h9) || (a.alarm_day_units_digit > 4'h9) ||
           (a.alarm_weekday_digit > 3'h6);
  endfunction : alarm_bad

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    st_d                = st_q;
    st_d.ctl.rdata      = 32'h0000_0000;
    st_d.ctl.wake_pulse = 1'b0;

    // three-stage pin synchronisers; a level counts once stages two and three agree
    st_d.ctl.sup_sync = {st_q.ctl.sup_sync[1:0], main_supply_ok_pin};
    st_d.ctl.slp_sync = {st_q.ctl.slp_sync[1:0], deep_sleep_req_pin};
    if (st_q.ctl.sup_sync[1] == st_q.ctl.sup_sync[2])
    begin
      st_d.ctl.supply_ok = st_q.ctl.sup_sync[2];
    end
    if (st_q.ctl.slp_sync[1] == st_q.ctl.slp_sync[2])
    begin
      st_d.ctl.sleep_req = st_q.ctl.slp_sync[2];
    end

    // register writes; a locked time write is dropped silently
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        `RTC_OFS_TIME:
        begin
          if (st_q.ctl.clock_write_unlock)                        // see R8
          begin
            st_d.tm = time_field(bus_req.wdata);
          end
        end
        `RTC_OFS_ALARM:  st_d.al = alarm_field(bus_req.wdata);
        `RTC_OFS_CLKCTL: st_d.ctl.clock_write_unlock = bus_req.wdata[`RTC_UNLOCK_BIT];
        `RTC_OFS_DSCTL:  st_d.ctl.deep_sleep_clock_disable = bus_req.wdata[`RTC_DSDIS_BIT];
        default:         ;
      endcase
    end

    // register reads, answered in the next cycle; unmapped reads give zero
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `RTC_OFS_TIME:   st_d.ctl.rdata = time_word(st_q.tm);
        `RTC_OFS_ALARM:  st_d.ctl.rdata = alarm_word(st_q.al);
        `RTC_OFS_CLKCTL: st_d.ctl.rdata[`RTC_UNLOCK_BIT] = st_q.ctl.clock_write_unlock;
        `RTC_OFS_DSCTL:  st_d.ctl.rdata[`RTC_DSDIS_BIT] = st_q.ctl.deep_sleep_clock_disable;
        `RTC_OFS_STATUS:
        begin
          st_d.ctl.rdata[`RTC_ST_RUN_BIT]  = st_q.ctl.clock_run;
          st_d.ctl.rdata[`RTC_ST_DEEP_BIT] = (st_q.ctl.pmode == RTC_PM_DEEP);
          st_d.ctl.rdata[`RTC_ST_BATT_BIT] = (st_q.ctl.pmode == RTC_PM_BATT);
          st_d.ctl.rdata[`RTC_ST_TBAD_BIT] = time_bad(st_q.tm);  // see R17
          st_d.ctl.rdata[`RTC_ST_ABAD_BIT] = alarm_bad(st_q.al);
        end
        default:         ;
      endcase
    end

    // power state: the disable bit is caught at the moment a low-power state is entered from run
    case (st_q.ctl.pmode)
      RTC_PM_RUN:
      begin
        if (!st_q.ctl.supply_ok)
        begin
          st_d.ctl.pmode           = RTC_PM_BATT;                  // see R16
          st_d.ctl.clk_off_latched = st_q.ctl.deep_sleep_clock_disable; // see R15
        end
        else if (st_q.ctl.sleep_req)
        begin
          st_d.ctl.pmode           = RTC_PM_DEEP;
          st_d.ctl.clk_off_latched = st_q.ctl.deep_sleep_clock_disable; // see R14
        end
      end
      RTC_PM_DEEP:
      begin
        // supply loss during deep sleep keeps the choice made at sleep entry
        if (!st_q.ctl.supply_ok)
        begin
          st_d.ctl.pmode = RTC_PM_BATT;                            // see R16
        end
        else if (!st_q.ctl.sleep_req)
        begin
          st_d.ctl.pmode = RTC_PM_RUN;
        end
      end
      RTC_PM_BATT:
      begin
        // only the return of main supply ends battery mode; software has no say
        if (st_q.ctl.supply_ok)
        begin
          st_d.ctl.pmode      = RTC_PM_RUN;
          st_d.ctl.wake_pulse = 1'b1;                              // see R16
        end
      end
      default: st_d.ctl.pmode = RTC_PM_RUN;
    endcase
    st_d.ctl.clock_run = (st_d.ctl.pmode == RTC_PM_RUN) || !st_d.ctl.clk_off_latched;
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  // digit fields take no reset so the time survives a backup-domain reset
  always_ff @(posedge sys_clk)
  begin
    st_q.tm <= st_d.tm;                                            // see R17
    st_q.al <= st_d.al;
    if (!reset_n)
    begin
      st_q.ctl           <= '0;
      st_q.ctl.sup_sync  <= `RTC_SYNC_RST;
      st_q.ctl.slp_sync  <= 3'b000;
      st_q.ctl.supply_ok <= 1'b1;
      st_q.ctl.clock_run <= 1'b1;
    end
    else
    begin
      st_q.ctl <= st_d.ctl;
    end
  end

  assign bus_rdata        = st_q.ctl.rdata;
  assign clock_run_enable = st_q.ctl.clock_run;
  assign deep_sleep_mode  = (st_q.ctl.pmode == RTC_PM_DEEP);
  assign battery_mode     = (st_q.ctl.pmode == RTC_PM_BATT);
  assign wake_por_pulse   = st_q.ctl.wake_pulse;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic t_wr_ok;
  logic t_wr_lk;
  logic t_rd;
  logic a_wr;
  logic a_rd;
  assign t_wr_ok = bus_req.wr && bus_req.addr == `RTC_OFS_TIME && st_q.ctl.clock_write_unlock;
  assign t_wr_lk = bus_req.wr && bus_req.addr == `RTC_OFS_TIME && !st_q.ctl.clock_write_unlock;
  assign t_rd    = bus_req.rd && bus_req.addr == `RTC_OFS_TIME;
  assign a_wr    = bus_req.wr && bus_req.addr == `RTC_OFS_ALARM;
  assign a_rd    = bus_req.rd && bus_req.addr == `RTC_OFS_ALARM;

  property p_r1;
    t_wr_ok ##1 t_rd |=> bus_rdata[29:28] == $past(bus_req.wdata[29:28], 2);
  endproperty
  a_r1: assert property (p_r1) else $error("hour tens digit lost"); // see R1

  property p_r2;
    t_wr_ok ##1 t_rd |=> bus_rdata[27:24] == $past(bus_req.wdata[27:24], 2);
  endproperty
  a_r2: assert property (p_r2) else $error("hour units digit lost"); // see R2

  property p_r3;
    t_wr_ok ##1 t_rd |=> bus_rdata[22:20] == $past(bus_req.wdata[22:20], 2);
  endproperty
  a_r3: assert property (p_r3) else $error("minute tens digit lost"); // see R3

  property p_r4;
    t_wr_ok ##1 t_rd |=> bus_rdata[19:16] == $past(bus_req.wdata[19:16], 2);
  endproperty
  a_r4: assert property (p_r4) else $error("minute units digit lost"); // see R4

  property p_r5;
    t_wr_ok ##1 t_rd |=> bus_rdata[14:12] == $past(bus_req.wdata[14:12], 2);
  endproperty
  a_r5: assert property (p_r5) else $error("second tens digit lost"); // see R5

  property p_r6;
    t_wr_ok ##1 t_rd |=> bus_rdata[11:8] == $past(bus_req.wdata[11:8], 2);
  endproperty
  a_r6: assert property (p_r6) else $error("second units digit lost"); // see R6

  property p_r7;
    t_rd |=> bus_rdata[31:30] == 2'h0 && !bus_rdata[23] && !bus_rdata[15]
             && bus_rdata[7:0] == 8'h00;
  endproperty
  a_r7: assert property (p_r7) else $error("unused time bits not zero"); // see R7

  property p_r7_alarm;
    a_rd |=> bus_rdata[31:21] == 11'h000 && bus_rdata[15:14] == 2'h0 && bus_rdata[7:3] == 5'h00;
  endproperty
  a_r7_alarm: assert property (p_r7_alarm) else $error("unused alarm bits not zero"); // see R7

  property p_r8;
    t_wr_lk ##1 t_rd |=> bus_rdata == $past(time_word(st_q.tm), 2);
  endproperty
  a_r8: assert property (p_r8) else $error("locked time write took effect"); // see R8

  property p_r9;
    a_wr ##1 a_rd |=> bus_rdata[20] == $past(bus_req.wdata[20], 2);
  endproperty
  a_r9: assert property (p_r9) else $error("month tens digit lost"); // see R9

  property p_r10;
    a_wr ##1 a_rd |=> bus_rdata[19:16] == $past(bus_req.wdata[19:16], 2);
  endproperty
  a_r10: assert property (p_r10) else $error("month units digit lost"); // see R10

  property p_r11;
    a_wr ##1 a_rd |=> bus_rdata[13:12] == $past(bus_req.wdata[13:12], 2);
  endproperty
  a_r11: assert property (p_r11) else $error("day tens digit lost"); // see R11

  property p_r12;
    a_wr ##1 a_rd |=> bus_rdata[11:8] == $past(bus_req.wdata[11:8], 2);
  endproperty
  a_r12: assert property (p_r12) else $error("day units digit lost"); // see R12

  property p_r13;
    a_wr ##1 a_rd |=> bus_rdata[2:0] == $past(bus_req.wdata[2:0], 2);
  endproperty
  a_r13: assert property (p_r13) else $error("weekday lost"); // see R13

  property p_r14;
    $rose(deep_sleep_mode) |-> clock_run_enable == !$past(st_q.ctl.deep_sleep_clock_disable);
  endproperty
  a_r14: assert property (p_r14) else $error("deep sleep clock choice wrong"); // see R14

  property p_r15;
    $rose(battery_mode) && $past(st_q.ctl.pmode == RTC_PM_RUN)
      |-> clock_run_enable == !$past(st_q.ctl.deep_sleep_clock_disable);
  endproperty
  a_r15: assert property (p_r15) else $error("battery clock choice wrong"); // see R15

  property p_r16;
    !main_supply_ok_pin [*6] |-> battery_mode;
  endproperty
  a_r16: assert property (p_r16) else $error("battery mode not entered"); // see R16

  property p_r16_wake;
    $fell(battery_mode) |-> wake_por_pulse && $past(st_q.ctl.supply_ok) ##1 !wake_por_pulse;
  endproperty
  a_r16_wake: assert property (p_r16_wake) else $error("wake pulse wrong"); // see R16

  c_time_wr_rd: cover property (t_wr_ok ##1 t_rd);
  c_locked_wr:  cover property (t_wr_lk);
  c_deep_off:   cover property ($rose(deep_sleep_mode) && !clock_run_enable);
  c_batt_wake:  cover property ($rose(battery_mode) ##[1:50] wake_por_pulse);

endmodule : rtc_time_alarm_regs
`default_nettype wire

// ### verif/rtc_time_alarm_regs_test.sv
// Purpose: self-checking bench for the clock register bank
// Assumes: bus read data is valid in the cycle after the read strobe; pins settle in 5 edges
// Notes:   digit fields start undefined, so each is written before it is ever compared
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_time_alarm_regs_test;
  import rtc_pkg::*;

  // ----------------------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------------------
  logic         sys_clk;
  logic         reset_n;
  rtc_bus_req_s bus_req;
  logic [31:0]  bus_rdata;
  logic         main_supply_ok_pin;
  logic         deep_sleep_req_pin;
  logic         clock_run_enable;
  logic         deep_sleep_mode;
  logic         battery_mode;
  logic         wake_por_pulse;
  int           err_total;
  int           tests_run;

  rtc_time_alarm_regs uut (
    .sys_clk            (sys_clk),
    .reset_n            (reset_n),
    .bus_req            (bus_req),
    .bus_rdata          (bus_rdata),
    .main_supply_ok_pin (main_supply_ok_pin),
    .deep_sleep_req_pin (deep_sleep_req_pin),
    .clock_run_enable   (clock_run_enable),
    .deep_sleep_mode    (deep_sleep_mode),
    .battery_mode       (battery_mode),
    .wake_por_pulse     (wake_por_pulse)
  );

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one-cycle write strobe; released at the next edge
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
  endtask : bus_wr

  // data is checked in the cycle after the strobe, where it stands, and must read zero one cycle later
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1 check(what, bus_rdata, exp);
    @(posedge sys_clk);
    #1 check("rdata idle", bus_rdata, 32'h0000_0000);
  endtask : rd_chk

  // write then read with no gap, so the back-to-back bus properties get exercised
  task wr_rd(input string what, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
    bus_req.rd    <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd    <= 1'b0;
    #1 check(what, bus_rdata, exp);
    @(posedge sys_clk);
    #1 check("rdata idle", bus_rdata, 32'h0000_0000);
  endtask : wr_rd

  // modes packed as {run enable, deep, battery, wake}; still old at edge 4, new at edge 5
  task pins(input logic sup, input logic slp, input logic [3:0] old_m, input logic [3:0] new_m);
    @(posedge sys_clk);
    main_supply_ok_pin <= sup;
    deep_sleep_req_pin <= slp;
    repeat (4) @(posedge sys_clk);
    #1 check("mode before", {28'h0, clock_run_enable, deep_sleep_mode, battery_mode,
                             wake_por_pulse}, {28'h0, old_m});
    @(posedge sys_clk);
    #1 check("mode after", {28'h0, clock_run_enable, deep_sleep_mode, battery_mode,
                            wake_por_pulse}, {28'h0, new_m});
  endtask : pins

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task t_reset;
    #1 check("reset modes", {28'h0, clock_run_enable, deep_sleep_mode, battery_mode,
                             wake_por_pulse}, 32'h0000_0008);
    rd_chk("unlock reset", `RTC_OFS_CLKCTL, 32'h0000_0000);
    rd_chk("disable reset", `RTC_OFS_DSCTL, 32'h0000_0000);
    rd_chk("unmapped read", 8'h40, 32'h0000_0000);
  endtask : t_reset

  task t_time;
    bus_wr(`RTC_OFS_CLKCTL, 32'h0000_0008);
    rd_chk("unlock set", `RTC_OFS_CLKCTL, 32'h0000_0008);
    bus_wr(`RTC_OFS_TIME, 32'h2359_5900);
    bus_wr(`RTC_OFS_CLKCTL, 32'hFFFF_FFF7);
    wr_rd("locked time", `RTC_OFS_TIME, 32'h0102_0300, 32'h2359_5900);
    bus_wr(`RTC_OFS_CLKCTL, 32'h0000_0008);
    wr_rd("time ones", `RTC_OFS_TIME, 32'hFFFF_FFFF, 32'h3F7F_7F00);
    wr_rd("time set", `RTC_OFS_TIME, 32'h1234_5600, 32'h1234_5600);
  endtask : t_time

  task t_alarm;
    wr_rd("alarm max", `RTC_OFS_ALARM, 32'hFFFF_FFFF, 32'h001F_3F07);
    rd_chk("status bad alarm", `RTC_OFS_STATUS, 32'h0000_0011);
    wr_rd("alarm set", `RTC_OFS_ALARM, 32'h0012_3106, 32'h0012_3106);
    bus_wr(`RTC_OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk("status clean", `RTC_OFS_STATUS, 32'h0000_0001);
  endtask : t_alarm

  // disable bit is latched at entry; battery wake must look like a power-on pulse
  task t_power;
    bus_wr(`RTC_OFS_DSCTL, 32'h0000_1000);
    rd_chk("disable set", `RTC_OFS_DSCTL, 32'h0000_1000);
    pins(1'b1, 1'b1, 4'b1000, 4'b0100);
    rd_chk("status deep", `RTC_OFS_STATUS, 32'h0000_0002);
    pins(1'b1, 1'b0, 4'b0100, 4'b1000);
    pins(1'b0, 1'b0, 4'b1000, 4'b0010);
    rd_chk("status battery", `RTC_OFS_STATUS, 32'h0000_0004);
    pins(1'b1, 1'b0, 4'b0010, 4'b1001);
    @(posedge sys_clk);
    #1 check("wake one cycle", {31'h0, wake_por_pulse}, 32'h0000_0000);
    bus_wr(`RTC_OFS_DSCTL, 32'h0000_0000);
    pins(1'b1, 1'b1, 4'b1000, 4'b1100);
    pins(1'b0, 1'b1, 4'b1100, 4'b1010);
    pins(1'b1, 1'b0, 4'b1010, 4'b1001);
  endtask : t_power

  // ----------------------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------------------
  initial
  begin
    err_total          = 0;
    tests_run          = 0;
    reset_n            = 1'b0;
    bus_req            = '0;
    main_supply_ok_pin = 1'b1;
    deep_sleep_req_pin = 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_time();
    t_alarm();
    t_power();
    finish_test();
  end

  // every wait above is bounded; this only cuts a stuck simulator short
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end

endmodule : rtc_time_alarm_regs_test

`default_nettype wire
